// *** pkg/adbh_pkg.sv ***
// Purpose: Shared constants and types for the ADC digital back end
// Assumes: 8-bit control registers, 24-bit audio words
// Notes:   Register map, field layout, reset values and link framing
package adbh_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_FMODE = 8'h03;
    localparam logic [7:0] ADDR_MISC = 8'h05;
    localparam logic [7:0] ADDR_GAIN_L = 8'h1c;
    localparam logic [7:0] ADDR_GAIN_R = 8'h1d;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_GPIO_BASE = 8'h29;
    localparam int GPIO_PINS = 7;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int SPEED_LSB = 6;
    localparam int CLK_SRC_BIT = 0;
    localparam int MCLK_SRC_BIT = 1;
    localparam int HOLD_BIT = 0;
    localparam int HPF_EN_BIT = 1;
    localparam int OVF_BIT = 0;
    localparam logic [7:0] FMODE_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h02;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] GPIO_RST = 8'h03;

    // Pin function codes
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_OVF = 2'h2;

    // Speed modes: ratio and highest sample rate in kHz
    localparam logic [7:0] OSR_SINGLE = 8'h80;
    localparam logic [7:0] OSR_DOUBLE = 8'h40;
    localparam logic [7:0] OSR_QUAD = 8'h20;
    localparam logic [7:0] KHZ_SINGLE = 8'd50;
    localparam logic [7:0] KHZ_DOUBLE = 8'd100;
    localparam logic [7:0] KHZ_QUAD = 8'd192;

    // ---------------------------------------------------------------
    // Datapath and link framing
    // ---------------------------------------------------------------
    localparam logic [23:0] POS_FS = 24'h7fffff;
    localparam logic [23:0] NEG_FS = 24'h800000;
    localparam int FRAC_W = 8;
    localparam int HPF_SHIFT = 10;
    localparam int GAIN_SHIFT = 6;
    localparam logic [7:0] GAIN_UNITY = 8'h40;
    localparam logic [7:0] HALF_BITS = 8'd96;
    localparam logic [7:0] FRAME_BITS = 8'd192;
    localparam logic [7:0] CAP_LAG = 8'd2;
    localparam logic [4:0] WORD_BITS = 5'd24;

    typedef enum logic [1:0] {
        ADBH_SINGLE,
        ADBH_DOUBLE,
        ADBH_QUAD
    } adbh_speed_type;

    typedef struct packed {
        logic hi;
        logic lo;
        logic [23:0] word;
    } adbh_chan_type;

endpackage

// *** logic/adbh_backend.sv ***
// Purpose: ADC back end: HPF, gain, saturation, one-line serial out
// Assumes: Decimated samples arrive on clk_i; link clock is free running
// Notes:   Control port decoded outside into a simple 8-bit access port
`timescale 1ns/10ps
module adbh_backend #(
    parameter int IN_W = 26,
    parameter int HPF_SHIFT = adbh_pkg::HPF_SHIFT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic adc_valid_i,
    input wire logic [IN_W-1:0] adc_left_i,
    input wire logic [IN_W-1:0] adc_right_i,
    output logic adc_word_valid_o,
    output logic [23:0] adc_left_o,
    output logic [23:0] adc_right_o,
    output logic [7:0] decim_ratio_o,
    output logic [7:0] rate_limit_khz_o,
    output logic sys_clk_sel_o,
    output logic master_clk_src_o,
    output logic [6:0] mfp_out_o,
    output logic [6:0] mfp_oe_n_o,
    input wire logic codec_bit_clk_i,
    input wire logic ext_converter_in_a_i,
    input wire logic ext_converter_in_b_i,
    output logic codec_frame_clock_o,
    output logic codec_serial_out_o
);

    localparam int FW = adbh_pkg::FRAC_W;
    localparam int EW = IN_W + FW;
    localparam int YW = IN_W + 1;
    localparam int PW = YW + 8;
    localparam int SW = PW - adbh_pkg::GAIN_SHIFT;
    localparam int GP = adbh_pkg::GPIO_PINS;
    localparam logic signed [SW-1:0] POS_L =
        SW'(signed'(adbh_pkg::POS_FS));
    localparam logic signed [SW-1:0] NEG_L =
        SW'(signed'(adbh_pkg::NEG_FS));

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Offset removal, gain and clamp for one channel
    function automatic adbh_pkg::adbh_chan_type chan_calc(
        input logic signed [IN_W-1:0] x,
        input logic signed [EW-1:0] e,
        input logic sub,
        input logic [5:0] g);
        logic signed [YW-1:0] y;
        logic signed [7:0] gm;
        logic signed [PW-1:0] p;
        logic signed [SW-1:0] s;
        adbh_pkg::adbh_chan_type r;
        y = sub ? YW'(x) - YW'(signed'(e[EW-1:FW])) : YW'(x);
        gm = 8'(signed'(g)) + signed'(adbh_pkg::GAIN_UNITY);
        p = PW'(y) * PW'(gm);
        s = SW'(p >>> adbh_pkg::GAIN_SHIFT);
        r.hi = s > POS_L;
        r.lo = s < NEG_L;
        r.word = r.hi ? adbh_pkg::POS_FS :
            (r.lo ? adbh_pkg::NEG_FS : s[23:0]);
        return r;
    endfunction

    // Speed field decode; reserved code falls back to single rate
    function automatic adbh_pkg::adbh_speed_type speed_of(
        input logic [1:0] f);
        case (f)
            2'h1: return adbh_pkg::ADBH_DOUBLE;
            2'h2: return adbh_pkg::ADBH_QUAD;
            default: return adbh_pkg::ADBH_SINGLE;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [7:0] fmode, next_fmode, misc, next_misc;
    logic [7:0] status, next_status, next_rdata;
    logic [7:0] gain [2];
    logic [7:0] next_gain [2];
    logic [7:0] gpio [GP];
    logic [7:0] next_gpio [GP];
    logic [7:0] next_ratio, next_khz;
    logic [6:0] next_mfp, next_oe_n;
    logic sat_any;
    adbh_pkg::adbh_speed_type speed;

    // Writes, status clear-on-read, and derived mode outputs
    always_comb
    begin
        next_fmode = fmode;
        next_misc = misc;
        next_gain = gain;
        next_gpio = gpio;
        next_status = status;
        next_rdata = reg_rdata_o;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                adbh_pkg::ADDR_FMODE: next_fmode = reg_wdata_i;
                adbh_pkg::ADDR_MISC: next_misc = reg_wdata_i;
                adbh_pkg::ADDR_GAIN_L: next_gain[0] = reg_wdata_i;
                adbh_pkg::ADDR_GAIN_R: next_gain[1] = reg_wdata_i;
                default: ;
            endcase
            for (int i = 0; i < GP; i++)
            begin
                if (reg_addr_i == 8'(adbh_pkg::ADDR_GPIO_BASE + i))
                    next_gpio[i] = reg_wdata_i;
            end
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                adbh_pkg::ADDR_FMODE: next_rdata = fmode;
                adbh_pkg::ADDR_MISC: next_rdata = misc;
                adbh_pkg::ADDR_GAIN_L: next_rdata = gain[0];
                adbh_pkg::ADDR_GAIN_R: next_rdata = gain[1];
                adbh_pkg::ADDR_STATUS: next_rdata = status;
                default: next_rdata = 8'h00;
            endcase
            for (int i = 0; i < GP; i++)
            begin
                if (reg_addr_i == 8'(adbh_pkg::ADDR_GPIO_BASE + i))
                    next_rdata = gpio[i];
            end
            if (reg_addr_i == adbh_pkg::ADDR_STATUS)
                next_status[adbh_pkg::OVF_BIT] = 1'b0;
        end
        // A saturation in the clearing cycle wins over the read
        if (adc_valid_i && sat_any)
            next_status[adbh_pkg::OVF_BIT] = 1'b1;
        speed = speed_of(fmode[adbh_pkg::SPEED_LSB +: 2]);
        case (speed)
            adbh_pkg::ADBH_DOUBLE:
            begin
                next_ratio = adbh_pkg::OSR_DOUBLE;
                next_khz = adbh_pkg::KHZ_DOUBLE;
            end
            adbh_pkg::ADBH_QUAD:
            begin
                next_ratio = adbh_pkg::OSR_QUAD;
                next_khz = adbh_pkg::KHZ_QUAD;
            end
            default:
            begin
                next_ratio = adbh_pkg::OSR_SINGLE;
                next_khz = adbh_pkg::KHZ_SINGLE;
            end
        endcase
        for (int i = 0; i < GP; i++)
        begin
            // Code 3 releases the pin for receiver input use
            next_oe_n[i] = &gpio[i][1:0];
            next_mfp[i] = (gpio[i][1:0] == adbh_pkg::PIN_HIGH) ||
                ((gpio[i][1:0] == adbh_pkg::PIN_OVF) &&
                status[adbh_pkg::OVF_BIT]);
        end
    end

    // Register state
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fmode <= adbh_pkg::FMODE_RST;
            misc <= adbh_pkg::MISC_RST;
            gain <= '{default: adbh_pkg::GAIN_RST};
            gpio <= '{default: adbh_pkg::GPIO_RST};
            status <= adbh_pkg::STATUS_RST;
            reg_rdata_o <= 8'h00;
            decim_ratio_o <= adbh_pkg::OSR_SINGLE;
            rate_limit_khz_o <= adbh_pkg::KHZ_SINGLE;
            sys_clk_sel_o <= 1'b0;
            master_clk_src_o <= 1'b0;
            mfp_out_o <= 7'h00;
            mfp_oe_n_o <= 7'h7f;
        end
        else
        begin
            fmode <= next_fmode;
            misc <= next_misc;
            gain <= next_gain;
            gpio <= next_gpio;
            status <= next_status;
            reg_rdata_o <= next_rdata;
            decim_ratio_o <= next_ratio;
            rate_limit_khz_o <= next_khz;
            sys_clk_sel_o <= fmode[adbh_pkg::CLK_SRC_BIT];
            master_clk_src_o <= fmode[adbh_pkg::MCLK_SRC_BIT];
            mfp_out_o <= next_mfp;
            mfp_oe_n_o <= next_oe_n;
        end
    end

    // ---------------------------------------------------------------
    // Sample datapath
    // ---------------------------------------------------------------
    logic signed [EW-1:0] est [2];
    logic signed [EW-1:0] next_est [2];
    logic [23:0] next_word [2];
    logic [1:0] res_hi, res_lo;
    logic tgl, next_tgl, hpf_en, hold;
    adbh_pkg::adbh_chan_type res [2];

    assign hpf_en = misc[adbh_pkg::HPF_EN_BIT];
    assign hold = misc[adbh_pkg::HOLD_BIT];

    // Held estimate is still subtracted even with the filter disabled
    always_comb
    begin
        next_est = est;
        next_tgl = tgl ^ adc_valid_i;
        for (int c = 0; c < 2; c++)
        begin
            logic signed [IN_W-1:0] x;
            logic signed [EW:0] d;
            x = signed'(c == 0 ? adc_left_i : adc_right_i);
            d = signed'({x[IN_W-1], x, {FW{1'b0}}}) -
                signed'({est[c][EW-1], est[c]});
            res[c] = chan_calc(x, est[c], hpf_en | hold,
                gain[c][5:0]);
            res_hi[c] = res[c].hi;
            res_lo[c] = res[c].lo;
            next_word[c] = res[c].word;
            if (adc_valid_i && hpf_en && !hold)
                next_est[c] = est[c] + EW'(d >>> HPF_SHIFT);
        end
        sat_any = |(res_hi | res_lo);
    end

    // Datapath state; words stay stable between samples for the link
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            est <= '{default: '0};
            tgl <= 1'b0;
            adc_word_valid_o <= 1'b0;
            adc_left_o <= 24'h000000;
            adc_right_o <= 24'h000000;
        end
        else
        begin
            est <= next_est;
            tgl <= next_tgl;
            adc_word_valid_o <= adc_valid_i;
            if (adc_valid_i)
            begin
                adc_left_o <= next_word[0];
                adc_right_o <= next_word[1];
            end
        end
    end

    // ---------------------------------------------------------------
    // Link domain: one-line serial output
    // ---------------------------------------------------------------
    logic lrst_s1, lrst, ea1, ea2, eb1, eb2, t1, t2, t3;
    logic [7:0] cnt, next_cnt, pos;
    logic [23:0] sha, shb, lw, rw, w;
    logic [23:0] next_sha, next_shb, next_lw, next_rw;
    logic next_sdo, nh;
    logic [4:0] nbit;

    // Reset release and pin/toggle synchronisers on the link clock
    always_ff @(posedge codec_bit_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lrst_s1 <= 1'b1;
            lrst <= 1'b1;
            {ea1, ea2, eb1, eb2, t1, t2, t3} <= 7'h00;
        end
        else
        begin
            lrst_s1 <= 1'b0;
            lrst <= lrst_s1;
            ea1 <= ext_converter_in_a_i;
            ea2 <= ea1;
            eb1 <= ext_converter_in_b_i;
            eb2 <= eb1;
            t1 <= tgl;
            t2 <= t1;
            t3 <= t2;
        end
    end

    // Slot order per half: internal, converter A, converter B
    always_comb
    begin
        next_cnt = (cnt == adbh_pkg::FRAME_BITS - 8'd1) ? 8'd0 :
            cnt + 8'd1;
        pos = (cnt >= adbh_pkg::HALF_BITS) ?
            cnt - adbh_pkg::HALF_BITS : cnt;
        next_sha = sha;
        next_shb = shb;
        if (pos >= adbh_pkg::CAP_LAG &&
            pos < adbh_pkg::CAP_LAG + 8'(adbh_pkg::WORD_BITS))
        begin
            next_sha = {sha[22:0], ea2};
            next_shb = {shb[22:0], eb2};
        end
        next_lw = lw;
        next_rw = rw;
        if (t2 ^ t3)
        begin
            next_lw = adc_left_o;
            next_rw = adc_right_o;
        end
        nh = next_cnt >= adbh_pkg::HALF_BITS;
        nbit = next_cnt[4:0] - (nh ? 5'd0 : 5'd0);
        case (nh ? (next_cnt - adbh_pkg::HALF_BITS) >> 5 : next_cnt >> 5)
            8'd0: w = nh ? rw : lw;
            8'd1: w = sha;
            default: w = shb;
        endcase
        next_sdo = (nbit < adbh_pkg::WORD_BITS) ?
            w[5'd23 - nbit] : 1'b0;
    end

    // Link state; the words are read only after the toggle settles
    always_ff @(posedge codec_bit_clk_i or posedge lrst)
    begin
        if (lrst)
        begin
            cnt <= 8'd0;
            sha <= 24'h000000;
            shb <= 24'h000000;
            lw <= 24'h000000;
            rw <= 24'h000000;
            codec_frame_clock_o <= 1'b1;
            codec_serial_out_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            sha <= next_sha;
            shb <= next_shb;
            lw <= next_lw;
            rw <= next_rw;
            codec_frame_clock_o <= !nh;
            codec_serial_out_o <= next_sdo;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_osr_single: assert property (@(posedge clk_i) disable iff (rst_i)
        fmode[7:6] == 2'h0 ##1 fmode[7:6] == 2'h0 |->
        decim_ratio_o == 8'h80 && rate_limit_khz_o == 8'd50)
        else $error("single mode ratio wrong");
    a_osr_double: assert property (@(posedge clk_i) disable iff (rst_i)
        fmode[7:6] == 2'h1 |=> decim_ratio_o == 8'h40 &&
        rate_limit_khz_o == 8'd100)
        else $error("double mode ratio wrong");
    a_osr_quad: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(fmode) && fmode[7:6] == 2'h2 |=>
        rate_limit_khz_o == 8'd192 && decim_ratio_o == 8'h20)
        else $error("quad mode ratio wrong");
    a_mode_write: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == 8'h03 |=> fmode == $past(reg_wdata_i))
        else $error("mode write lost");
    a_sat_high: assert property (@(posedge clk_i) disable iff (rst_i)
        adc_valid_i && res_hi[0] |=> adc_left_o == 24'h7fffff)
        else $error("positive clamp wrong");
    a_sat_low: assert property (@(posedge clk_i) disable iff (rst_i)
        adc_valid_i && res_lo[1] |=> adc_right_o == 24'h800000)
        else $error("negative clamp wrong");
    a_ovf_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        adc_valid_i && sat_any |=> status[0] ##1
        (status[0] || $past(reg_rd_i && reg_addr_i == 8'h20)))
        else $error("overflow flag not set");
    a_pin_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
        gpio[0][1:0] == 2'h2 && status[0] |=> mfp_out_o[0] &&
        !mfp_oe_n_o[0])
        else $error("overflow pin idle");
    a_hold_est: assert property (@(posedge clk_i) disable iff (rst_i)
        misc[0] [*2] |-> $stable(est[0]) && $stable(est[1]))
        else $error("held estimate moved");
    a_plain_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        adc_valid_i && misc[1:0] == 2'h0 && gain[0][5:0] == 6'h00 &&
        adc_left_i[IN_W-1:23] == '0 |=>
        adc_left_o == $past(adc_left_i[23:0]))
        else $error("bypass altered sample");
    a_clk_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == 8'h03 |-> ##2
        sys_clk_sel_o == $past(reg_wdata_i[0], 2))
        else $error("clock select stale");
    a_frame_edge: assert property (
        @(posedge codec_bit_clk_i) disable iff (lrst)
        cnt == 8'd94 |=> ##1 $fell(codec_frame_clock_o) ##96
        $rose(codec_frame_clock_o))
        else $error("frame clock edge misplaced");
    c_saturate: cover property (@(posedge clk_i) disable iff (rst_i)
        adc_valid_i && sat_any);
    c_hold_run: cover property (@(posedge clk_i) disable iff (rst_i)
        misc[1:0] == 2'h1 && adc_valid_i);
    c_new_word: cover property (
        @(posedge codec_bit_clk_i) disable iff (lrst) (t2 ^ t3) && cnt == 0);

endmodule

// *** verification/adbh_host_model.sv ***
// Purpose: Host and external converter model on the one-line link
// Assumes: Frame clock high marks the left half
// Notes:   Ext bits change just after each rising link edge
`timescale 1ns/10ps
module adbh_host_model #(
    parameter logic [95:0] EXT_WORDS = 96'ha1b2c3_1c2d3e_5a5a5a_e1f203
) (
    input wire logic bclk_i,
    input wire logic frame_i,
    input wire logic sdata_i,
    output logic ext_a_o,
    output logic ext_b_o,
    output logic [143:0] rx_o,
    output int pad_err_o
);
    logic last = 1'b1;
    logic sync = 1'b0;
    logic [31:0] sh = 32'h0;
    int pos = 0;
    int h;
    initial
    begin
        ext_a_o = 1'b0;
        ext_b_o = 1'b0;
        rx_o = '0;
        pad_err_o = 0;
    end
    // Track half position; off-slot ext bits toggle so a late grab shows
    always @(posedge bclk_i)
    begin
        #2;
        sync = sync | (frame_i != last);
        pos = (frame_i != last) ? 0 : pos + 1;
        last = frame_i;
        h = frame_i ? 0 : 1;
        sh = {sh[30:0], sdata_i};
        ext_a_o = pos < 24 ? EXT_WORDS[95 - 24 * h - pos] : pos[0];
        ext_b_o = pos < 24 ? EXT_WORDS[47 - 24 * h - pos] : pos[0];
        if (sync && pos < 96 && pos % 32 == 31)
        begin
            rx_o[(h * 3 + pos / 32) * 24 +: 24] = sh[31:8];
            pad_err_o += (sh[7:0] != 8'h00);
        end
    end
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the ADC back end
// Assumes: Register strobes are one-cycle pulses
// Notes:   Filter shift cut to 2 so settling fits a short run
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic bclk = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic vld = 1'b0;
    logic [25:0] l_in = 26'h0;
    logic [25:0] r_in = 26'h0;
    logic [7:0] rdata, ratio, khz;
    logic word_v, clk_sel, mclk_src, ext_a, ext_b, frame, sdata;
    logic [23:0] l_out, r_out;
    logic [6:0] pin, pin_oe_n;
    logic [143:0] rx;
    int pad_err;
    int err_total = 0;
    int total_checks = 0;
    always #4 clk_i = ~clk_i;
    // Offset link clock so its edges never line up with clk_i
    initial
    begin
        #3;
        forever #24 bclk = ~bclk;
    end
    adbh_backend #(.IN_W(26), .HPF_SHIFT(2)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .adc_valid_i(vld), .adc_left_i(l_in),
        .adc_right_i(r_in), .adc_word_valid_o(word_v),
        .adc_left_o(l_out), .adc_right_o(r_out), .decim_ratio_o(ratio),
        .rate_limit_khz_o(khz), .sys_clk_sel_o(clk_sel),
        .master_clk_src_o(mclk_src), .mfp_out_o(pin),
        .mfp_oe_n_o(pin_oe_n), .codec_bit_clk_i(bclk),
        .ext_converter_in_a_i(ext_a), .ext_converter_in_b_i(ext_b),
        .codec_frame_clock_o(frame), .codec_serial_out_o(sdata)
    );
    adbh_host_model u_host (
        .bclk_i(bclk), .frame_i(frame), .sdata_i(sdata),
        .ext_a_o(ext_a), .ext_b_o(ext_b), .rx_o(rx), .pad_err_o(pad_err)
    );
    // ---------------------------------------------------------------
    // Shared checks and port tasks
    // ---------------------------------------------------------------
    task automatic near(string nm, logic [23:0] e, logic [23:0] g, int t);
        int d;
        d = int'($signed(g)) - int'($signed(e));
        total_checks++;
        if ((^g === 1'bx) || d > t || d < -t)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic eq8(string nm, logic [7:0] e, logic [7:0] g);
        near(nm, {16'h0, e}, {16'h0, g}, 0);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(posedge clk_i);
        #1;
        wr_s = 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
        @(posedge clk_i);
        #1;
        addr = a;
        rd_s = 1'b1;
        @(posedge clk_i);
        #1;
        rd_s = 1'b0;
        eq8(nm, e, rdata);
    endtask
    // Samples kept 300 cycles apart so the link crossing keeps up
    task automatic smp(logic [25:0] l, logic [25:0] r);
        @(posedge clk_i);
        #1;
        l_in = l;
        r_in = r;
        vld = 1'b1;
        @(posedge clk_i);
        #1;
        vld = 1'b0;
        eq8("word_valid", 8'h01, {7'h0, word_v});
        repeat (300) @(posedge clk_i);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_speed();
        logic [7:0] er, ek;
        for (int m = 0; m < 4; m++)
        begin
            er = m == 1 ? 8'h40 : m == 2 ? 8'h20 : 8'h80;
            ek = m == 1 ? 8'h64 : m == 2 ? 8'hc0 : 8'h32;
            wr(adbh_pkg::ADDR_FMODE, {m[1:0], 4'h0, m[1], m[0]});
            eq8("ratio", er, ratio);
            eq8("rate", ek, khz);
            eq8("clk_sel", {7'h0, m[0]}, {7'h0, clk_sel});
            eq8("mclk_src", {7'h0, m[1]}, {7'h0, mclk_src});
        end
        wr(adbh_pkg::ADDR_FMODE, 8'h00);
    endtask
    task automatic t_ovf();
        wr(adbh_pkg::ADDR_GPIO_BASE, 8'h02);
        wr(8'h2a, 8'h01);
        wr(8'h2b, 8'h00);
        eq8("pins", 8'h02, {5'h0, pin[2:0]});
        eq8("pin_oe", 8'h78, {1'b0, pin_oe_n});
        smp(26'h1000000, 26'h0000010);
        near("sat_pos", adbh_pkg::POS_FS, l_out, 0);
        near("pass", 24'h10, r_out, 0);
        eq8("pin_ovf", 8'h01, {7'h0, pin[0]});
        rd(adbh_pkg::ADDR_STATUS, 8'h01, "ovf_set");
        rd(adbh_pkg::ADDR_STATUS, 8'h00, "ovf_clear");
        wr(adbh_pkg::ADDR_STATUS, 8'h01);
        rd(adbh_pkg::ADDR_STATUS, 8'h00, "status_ro");
        smp(26'h0000020, 26'h2ffffff);
        near("sat_neg", adbh_pkg::NEG_FS, r_out, 0);
        rd(adbh_pkg::ADDR_STATUS, 8'h01, "ovf_neg");
        rd(8'h40, 8'h00, "unmapped");
    endtask
    task automatic t_gain();
        wr(adbh_pkg::ADDR_GAIN_L, 8'h10);
        wr(adbh_pkg::ADDR_GAIN_R, 8'h30);
        smp(26'h0000400, 26'h3fffc00);
        near("gain_l", 24'h000500, l_out, 0);
        near("gain_r", 24'hfffd00, r_out, 0);
        wr(adbh_pkg::ADDR_GAIN_L, 8'h00);
        wr(adbh_pkg::ADDR_GAIN_R, 8'h00);
    endtask
    task automatic t_link();
        logic [143:0] e;
        e = 144'he1f203_1c2d3e_fedcba_5a5a5a_a1b2c3_123456;
        smp(26'h0123456, 26'h3fedcba);
        repeat (3000) @(posedge clk_i);
        for (int k = 0; k < 6; k++)
            near("link_word", e[k * 24 +: 24], rx[k * 24 +: 24], 0);
        near("pad_bits", 24'h0, pad_err[23:0], 0);
    endtask
    task automatic t_hpf();
        wr(adbh_pkg::ADDR_MISC, 8'h02);
        repeat (30) smp(26'h1000, 26'h1000);
        near("hpf_l", 24'h0, l_out, 4);
        near("hpf_r", 24'h0, r_out, 4);
        // Filter settled: disable it and hold the offset
        wr(adbh_pkg::ADDR_MISC, 8'h01);
        repeat (2)
        begin
            smp(26'h1400, 26'h1200);
            near("hold_l", 24'h400, l_out, 4);
            near("hold_r", 24'h200, r_out, 4);
        end
        // Hold must win over enable: estimate stays frozen
        wr(adbh_pkg::ADDR_MISC, 8'h03);
        smp(26'h1400, 26'h1200);
        near("hold_en_l", 24'h400, l_out, 4);
        wr(adbh_pkg::ADDR_MISC, 8'h02);
        repeat (30) smp(26'h1400, 26'h1200);
        near("resume", 24'h0, l_out, 4);
    endtask
    task automatic finish_test();
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence; reset also spans three link edges
    initial
    begin
        repeat (10) @(posedge clk_i);
        repeat (3) @(posedge bclk);
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd(adbh_pkg::ADDR_FMODE, adbh_pkg::FMODE_RST, "fmode_rst");
        rd(adbh_pkg::ADDR_MISC, adbh_pkg::MISC_RST, "misc_rst");
        wr(adbh_pkg::ADDR_MISC, 8'h00);
        t_speed();
        t_ovf();
        t_gain();
        t_link();
        t_hpf();
        finish_test();
    end
    // Watchdog well past the roughly 200 us the tests need
    initial
    begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule
